// file: include/adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define ADC_SAMPLE_CYCLES 4'h4
`define ADC_TOTAL_CYCLES 4'hf
`define ADC_SAR_FIRST 12'h800
`define ADC_SRC_EXT_A 4'h0
`define ADC_SRC_EXT_B 4'h4
`define ADC_REF_AMP 2'h1
`define ADC_FMT_LEFT 1'h0
`endif

// file: include/adc_seq_pkg.sv
package adc_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SAMPLE = 3'h2,
      ST_CONVERT = 3'h4
   } seq_state_t;

   typedef struct packed {
      seq_state_t state;
      logic [3:0] count;
      logic [11:0] sar;
      logic startHigh;
      logic irqFlag;
      logic [7:0] resHigh;
      logic [7:0] resLow;
   } seq_regs_t;

   typedef struct packed {
      logic [6:0] cnt;
   } div_regs_t;
endpackage

// file: hw/adc_clock_divider.sv
`timescale 1ns/1ns
module adc_clock_divider (
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic restart,
   input wire logic [2:0] divSel,
   output logic tick
);
   adc_seq_pkg::div_regs_t r_r;
   adc_seq_pkg::div_regs_t r_nxt;
   logic [6:0] mask;

   // ----------------------------------------
   // power-of-two divider, tick on last count
   // ----------------------------------------
   always_comb begin
      mask = 7'((8'h01 << divSel) - 8'h01);
      tick = (r_r.cnt & mask) == mask;
      r_nxt = r_r;
      if (restart) begin
         r_nxt.cnt = 7'h00;
      end else begin
         r_nxt.cnt = r_r.cnt + 7'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_r <= '0;
      end else if (clkEn) begin
         r_r <= r_nxt;
      end
   end
endmodule

// file: hw/adc_conversion_sequencer.sv
`timescale 1ns/1ns
`include "adc_seq_defines.svh"
module adc_conversion_sequencer (
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic adcPowerEnable,
   input wire logic startBit,
   input wire logic [2:0] clockDivideSelect,
   input wire logic [3:0] inputSourceSelect,
   input wire logic [3:0] channelSelect,
   input wire logic resultFormatSelect,
   input wire logic [1:0] referenceSelect,
   input wire logic globalIrqEnable,
   input wire logic adcIrqEnable,
   input wire logic adcIrqFlagClear,
   input wire logic comparatorHigh,
   output logic analogPowerOn,
   output logic samplingActive,
   output logic [11:0] sarTrial,
   output logic externalChannelEnable,
   output logic [3:0] externalChannel,
   output logic [3:0] internalSelect,
   output logic groundSelect,
   output logic [1:0] referenceSource,
   output logic ampReferenceActive,
   output logic conversionBusyFlag,
   output logic [7:0] resultHighByte,
   output logic [7:0] resultLowByte,
   output logic adcIrqFlag,
   output logic adcIrqRequest
);
   adc_seq_pkg::seq_regs_t r_r;
   adc_seq_pkg::seq_regs_t r_nxt;
   logic tick;
   logic trigger;
   logic done;
   logic idle;
   logic isExt;
   logic isGnd;
   logic [3:0] bitIdx;
   logic [11:0] code;

   // ----------------------------------------
   // converter clock
   // ----------------------------------------
   // divider restarts on every trigger so conversion length is exact
   adc_clock_divider u_div (
      .clk(clk),
      .rst(rst),
      .clkEn(clkEn),
      .restart(trigger || idle),
      .divSel(clockDivideSelect),
      .tick(tick)
   );

   // ----------------------------------------
   // input, reference and power routing
   // ----------------------------------------
   always_comb begin
      isExt = inputSourceSelect == `ADC_SRC_EXT_A || inputSourceSelect == `ADC_SRC_EXT_B
         || inputSourceSelect[3:2] == 2'h3;
      isGnd = inputSourceSelect[3:2] == 2'h2;
      externalChannelEnable = adcPowerEnable && isExt;
      externalChannel = isExt ? channelSelect : 4'h0;
      // internal signal replaces the pin, which is then cut off
      internalSelect = (!isExt && !isGnd) ? inputSourceSelect : 4'h0;
      groundSelect = isGnd;
      referenceSource = referenceSelect;
      ampReferenceActive = referenceSelect == `ADC_REF_AMP;
      analogPowerOn = adcPowerEnable;
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      idle = r_r.state == adc_seq_pkg::ST_IDLE;
      // falling edge of a start bit already seen high
      trigger = adcPowerEnable && r_r.startHigh && !startBit;
      done = adcPowerEnable && !trigger && tick && r_r.state == adc_seq_pkg::ST_CONVERT
         && r_r.count == `ADC_TOTAL_CYCLES;
      bitIdx = `ADC_TOTAL_CYCLES - r_r.count;
      r_nxt = r_r;
      r_nxt.startHigh = adcPowerEnable && startBit;
      if (!adcPowerEnable) begin
         r_nxt.state = adc_seq_pkg::ST_IDLE;
         r_nxt.count = 4'h0;
      end else if (trigger) begin
         r_nxt.state = adc_seq_pkg::ST_SAMPLE;
         r_nxt.count = 4'h0;
         r_nxt.sar = 12'h000;
      end else if (tick) begin
         case (r_r.state)
            adc_seq_pkg::ST_SAMPLE: begin
               r_nxt.count = r_r.count + 4'h1;
               if (r_r.count == `ADC_SAMPLE_CYCLES - 4'h1) begin
                  r_nxt.state = adc_seq_pkg::ST_CONVERT;
                  r_nxt.sar = `ADC_SAR_FIRST;
               end
            end
            adc_seq_pkg::ST_CONVERT: begin
               // one bit decided per converter clock, msb first
               r_nxt.count = r_r.count + 4'h1;
               r_nxt.sar[bitIdx] = comparatorHigh;
               if (bitIdx != 4'h0) begin
                  r_nxt.sar[bitIdx - 4'h1] = 1'b1;
               end
               if (r_r.count == `ADC_TOTAL_CYCLES) begin
                  r_nxt.state = adc_seq_pkg::ST_IDLE;
                  r_nxt.count = 4'h0;
               end
            end
            default: begin
               r_nxt.count = 4'h0;
            end
         endcase
      end
      code = r_nxt.sar;
      // result bytes only move at completion
      if (done) begin
         if (resultFormatSelect == `ADC_FMT_LEFT) begin
            r_nxt.resHigh = code[11:4];
            r_nxt.resLow = {code[3:0], 4'h0};
         end else begin
            r_nxt.resHigh = {4'h0, code[11:8]};
            r_nxt.resLow = code[7:0];
         end
      end
      // a completion in the clearing cycle wins over the clear
      if (done) begin
         r_nxt.irqFlag = 1'b1;
      end else if (adcIrqFlagClear) begin
         r_nxt.irqFlag = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_r <= '{state: adc_seq_pkg::ST_IDLE, count: 4'h0, sar: 12'h000, startHigh: 1'b0,
            irqFlag: 1'b0, resHigh: 8'h00, resLow: 8'h00};
      end else if (clkEn) begin
         r_r <= r_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_comb begin
      conversionBusyFlag = !idle;
      samplingActive = adcPowerEnable && r_r.state == adc_seq_pkg::ST_SAMPLE;
      sarTrial = r_r.sar;
      resultHighByte = r_r.resHigh;
      resultLowByte = r_r.resLow;
      adcIrqFlag = r_r.irqFlag;
      adcIrqRequest = r_r.irqFlag && globalIrqEnable && adcIrqEnable;
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   logic [11:0] busyLen;
   logic [2:0] divAtStart;

   // helper: busy length measured from the trigger
   always_ff @(posedge clk) begin
      if (rst) begin
         busyLen <= 12'h000;
         divAtStart <= 3'h0;
      end else if (clkEn) begin
         if (trigger) begin
            busyLen <= 12'h000;
            divAtStart <= clockDivideSelect;
         end else if (!idle) begin
            busyLen <= busyLen + 12'h001;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !clkEn);

   a_start_busy: assert property (trigger |=> conversionBusyFlag)
      else $error("trigger did not raise busy");
   a_no_start_high: assert property (!$past(r_r.startHigh) && $rose(conversionBusyFlag)
      |-> 1'b0) else $error("busy rose without a start pulse");
   a_power_abort: assert property (!adcPowerEnable |=> !conversionBusyFlag)
      else $error("busy survived power off");
   a_abort_no_flag: assert property (!adcPowerEnable && !adcIrqFlag |=> !adcIrqFlag)
      else $error("flag set while powered off");
   // power seen high one cycle before the fall means the fall was a completion, not an abort
   a_done_flag: assert property ($fell(conversionBusyFlag) && $past(adcPowerEnable)
      |-> adcIrqFlag) else $error("completion did not set flag");
   a_conv_length: assert property ($fell(conversionBusyFlag) && $past(adcPowerEnable)
      |-> busyLen == (12'h010 << divAtStart))
      else $error("conversion length wrong for divider");
   // a restart, an abort or a divider change legally stretches or cuts the sampling phase
   a_sample_four: assert property (disable iff (rst || !clkEn || !adcPowerEnable || trigger
      || clockDivideSelect != 3'h0) $rose(samplingActive) && clockDivideSelect == 3'h0
      |-> samplingActive [*4] ##1 !samplingActive)
      else $error("sampling phase not four clocks");
   a_result_hold: assert property (conversionBusyFlag && !done |=> $stable(resultHighByte)
      && $stable(resultLowByte)) else $error("result moved before completion");
   a_irq_gate: assert property ($rose(adcIrqRequest) |-> globalIrqEnable && adcIrqEnable
      && adcIrqFlag) else $error("interrupt without enables");
   a_ext_cut: assert property (internalSelect != 4'h0 |-> !externalChannelEnable)
      else $error("external input left connected");
   a_power_gate: assert property (!adcPowerEnable |-> !analogPowerOn && !samplingActive)
      else $error("converter active while unpowered");

   c_conv_done: cover property ($fell(conversionBusyFlag) && adcPowerEnable);
   c_restart: cover property (conversionBusyFlag && trigger);
   c_abort: cover property (conversionBusyFlag && !adcPowerEnable);
   c_irq: cover property ($rose(adcIrqRequest));
endmodule

// file: bench/tb.sv
`timescale 1ns/1ns
module tb;
   logic clk, rst, clkEn, adcPowerEnable, startBit, resultFormatSelect, comparatorHigh;
   logic globalIrqEnable, adcIrqEnable, adcIrqFlagClear;
   logic analogPowerOn, samplingActive, externalChannelEnable, groundSelect;
   logic ampReferenceActive, conversionBusyFlag, adcIrqFlag, adcIrqRequest;
   logic [2:0] clockDivideSelect;
   logic [3:0] inputSourceSelect, channelSelect, externalChannel, internalSelect;
   logic [1:0] referenceSelect, referenceSource;
   logic [11:0] sarTrial, target;
   logic [7:0] resultHighByte, resultLowByte;
   logic ext, gnd;
   logic [3:0] expCh, expInt;
   logic [11:0] held;
   int nMismatch = 0;
   int checksDone = 0;
   int cyc;

   adc_conversion_sequencer adc_conversion_sequencer_inst (.clk(clk), .rst(rst), .clkEn(clkEn),
      .adcPowerEnable(adcPowerEnable), .startBit(startBit),
      .clockDivideSelect(clockDivideSelect), .inputSourceSelect(inputSourceSelect),
      .channelSelect(channelSelect), .resultFormatSelect(resultFormatSelect),
      .referenceSelect(referenceSelect), .globalIrqEnable(globalIrqEnable),
      .adcIrqEnable(adcIrqEnable), .adcIrqFlagClear(adcIrqFlagClear),
      .comparatorHigh(comparatorHigh), .analogPowerOn(analogPowerOn),
      .samplingActive(samplingActive), .sarTrial(sarTrial),
      .externalChannelEnable(externalChannelEnable), .externalChannel(externalChannel),
      .internalSelect(internalSelect), .groundSelect(groundSelect),
      .referenceSource(referenceSource), .ampReferenceActive(ampReferenceActive),
      .conversionBusyFlag(conversionBusyFlag), .resultHighByte(resultHighByte),
      .resultLowByte(resultLowByte), .adcIrqFlag(adcIrqFlag), .adcIrqRequest(adcIrqRequest));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ideal analog input: comparator answers for the trial code now on sarTrial
   always @(negedge clk) comparatorHigh <= (target >= sarTrial);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nMismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // pulse the start bit, then count negedges with busy high
   task automatic convert(input logic [2:0] n, input logic [11:0] tgt);
      clockDivideSelect = n;
      target = tgt;
      startBit = 1'b1;
      @(negedge clk);
      startBit = 1'b0;
      @(negedge clk);
      cyc = 0;
      while (conversionBusyFlag === 1'b1 && cyc < 5000) begin
         if (cyc == 0) chk(samplingActive, 1'b1);
         if (n == 3'h0 && cyc == 4) chk({samplingActive, 3'h0, sarTrial}, 16'h0800);
         cyc++;
         @(negedge clk);
      end
   endtask

   task automatic chkres(input logic [11:0] tgt);
      if (resultFormatSelect) chk({resultHighByte, resultLowByte}, {4'h0, tgt});
      else chk({resultHighByte, resultLowByte}, {tgt, 4'h0});
   endtask

   initial begin
      #200000;
      nMismatch++;
      results();
   end

   initial begin
      {rst, clkEn, adcPowerEnable, startBit, resultFormatSelect} = 5'b11000;
      {globalIrqEnable, adcIrqEnable, adcIrqFlagClear} = 3'b000;
      {clockDivideSelect, inputSourceSelect, channelSelect, referenceSelect} = 13'h0;
      target = 12'h0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      chk({conversionBusyFlag, adcIrqFlag, resultHighByte, resultLowByte}, 18'h0);
      // a start with power off is ignored
      convert(3'h0, 12'h123);
      chk({analogPowerOn, conversionBusyFlag, adcIrqFlag}, 3'b000);
      adcPowerEnable = 1'b1;
      repeat (4) @(negedge clk);
      $display("test reset and power-off start done");
      // every divide code, both formats, full-scale code at divide 0
      for (int i = 0; i < 8; i++) begin
         resultFormatSelect = i[0];
         convert(i[2:0], (i == 0) ? 12'hfff : 12'h5a3 + 12'(i));
         chk(16'(cyc), 16'(16 << i));
         chkres((i == 0) ? 12'hfff : 12'h5a3 + 12'(i));
         chk(adcIrqFlag, 1'b1);
      end
      $display("test divide and format done");
      // interrupt gating over all enable combinations
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         {globalIrqEnable, adcIrqEnable} = i[1:0];
         #1 chk(adcIrqRequest, i == 3);
      end
      @(negedge clk);
      adcIrqFlagClear = 1'b1;
      @(negedge clk);
      adcIrqFlagClear = 1'b0;
      chk({adcIrqFlag, adcIrqRequest}, 2'b00);
      $display("test interrupt done");
      // restart in mid-conversion keeps old result until the new one lands
      resultFormatSelect = 1'b1;
      convert(3'h0, 12'h000);
      chkres(12'h000);
      target = 12'h9c4;
      startBit = 1'b1;
      repeat (2) @(negedge clk);
      startBit = 1'b0;
      repeat (6) @(negedge clk);
      chk({conversionBusyFlag, resultHighByte, resultLowByte}, 17'h10000);
      // clock enable low freezes the sequence in mid-conversion
      clkEn = 1'b0;
      held = sarTrial;
      repeat (3) @(negedge clk);
      chk({conversionBusyFlag, samplingActive, sarTrial}, {2'b10, held});
      clkEn = 1'b1;
      convert(3'h0, 12'h9c4);
      chk(16'(cyc), 16'd16);
      chkres(12'h9c4);
      adcIrqFlagClear = 1'b1;
      @(negedge clk);
      adcIrqFlagClear = 1'b0;
      $display("test restart done");
      // power dropped in mid-conversion aborts without a completion
      startBit = 1'b1;
      @(negedge clk);
      startBit = 1'b0;
      repeat (6) @(negedge clk);
      adcPowerEnable = 1'b0;
      @(negedge clk);
      chk({conversionBusyFlag, adcIrqFlag, analogPowerOn}, 3'b000);
      repeat (20) @(negedge clk);
      chk({adcIrqFlag, resultHighByte, resultLowByte}, {1'b0, 16'h09c4});
      $display("test power abort done");
      // input routing for every source code, with power off and on
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            adcPowerEnable = p[0];
            inputSourceSelect = i[3:0];
            channelSelect = ~i[3:0];
            referenceSelect = i[1:0];
            ext = (i == 0 || i == 4 || i[3:2] == 2'h3);
            gnd = (i[3:2] == 2'h2);
            expCh = ext ? ~i[3:0] : 4'h0;
            expInt = (!ext && !gnd) ? i[3:0] : 4'h0;
            #1 chk({externalChannelEnable, externalChannel}, {ext & p[0], expCh});
            chk({groundSelect, internalSelect}, {gnd, expInt});
            chk({referenceSource, ampReferenceActive}, {i[1:0], i[1:0] == 2'h1});
         end
      end
      $display("test routing done");
      results();
   end
endmodule
